// [rtl/cpw_compare_pair.sv]
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - mode 00, up-only timers: ch1 single-toggle if select 0, double if 1
// - modes 01/10/11 make ch0/ch1/both up/down; select 1 means active low
// - six-bit mode field gives two bits per pair, chosen by pair index
// - direction mode for each channel comes from its selected timer
// - outputs change only on a running channel's match, or on up/down compare 0x0000/0xffff
// - single-toggle inverts output 0 on every match, any value, any direction
// - single-toggle output 1 inverts on compare 1 match, channels independent
// - double-toggle inverts output 1 on match with compare 0 or compare 1
// - with ch1 double-toggle, ch0 keeps single-toggle on compare 0
// - single-toggle compare above peak never matches, output holds
// - up/down match while counting up drives output active
// - up/down match while counting down drives output inactive
// - up/down compare 0x0000 holds output active while in place
// - up/down compare 0xffff holds output inactive while in place
// - up/down match at peak changes no output and sets no flag
// - peak equals the selected timer's cycle setting value
// - zero-point transfer loads compare at count zero
// - peak-point transfer loads at peak and compares in the same step
// - active level high in active-high mode, low in active-low mode
// - match flags set on compare 0 and compare 1 matches
module cpw_compare_pair #(
   parameter int PAIR_IDX = 0,
   parameter int N_TMR    = 3
) (
   input  wire logic                              CLK_SYS,
   input  wire logic                              RST_N,
   input  wire logic                              PSEL,
   input  wire logic                              PENABLE,
   input  wire logic                              PWRITE,
   input  wire logic [cpw_pkg::AW-1:0]            PADDR,
   input  wire logic [31:0]                       PWDATA,
   output logic      [31:0]                       PRDATA,
   output logic                                   PREADY,
   output logic                                   PSLVERR,
   input  wire cpw_pkg::cpw_tmr_t [N_TMR-1:0]     TIMERS,
   output logic      [1:0]                        RT_OUT,
   output logic      [1:0]                        MATCH_FLAG
);

   // parameters the logic cannot serve
   if (PAIR_IDX < 0 || PAIR_IDX > 2) begin : g_chk_pair
      $error("PAIR_IDX must be 0, 1 or 2");
   end
   if (N_TMR < 1 || N_TMR > 4) begin : g_chk_tmr
      $error("N_TMR must be 1 to 4");
   end

   logic                     rst_meta_r;
   logic                     rst_n;
   cpw_pkg::cpw_ctrl_t       ctrl_r;
   logic [1:0][cpw_pkg::CW-1:0] buf_r;
   logic [1:0][cpw_pkg::CW-1:0] cv_r;
   logic [1:0]               rt_r;
   logic [1:0]               rt_nxt;
   logic [1:0]               flag_r;
   logic [1:0]               flag_nxt;
   logic [31:0]              prdata_r;
   logic                     pready_r;
   logic                     pslverr_r;
   cpw_pkg::cpw_tmr_t [1:0]  tm;
   cpw_pkg::cpw_mode_t [1:0] mode;
   logic [1:0]               mf;
   logic [1:0]               load;
   logic [1:0][cpw_pkg::CW-1:0] eff;
   logic [1:0]               hit;
   logic [1:0]               at_pk;
   logic [1:0]               ud;
   logic [1:0]               act;
   logic                     setup;
   logic                     wr_en;
   logic                     mapped;

   // channel mode from mode bits, select bit and both channels' timer modes
   function automatic cpw_pkg::cpw_mode_t ch_mode(input logic       ch1,
                                                  input logic [1:0] mfld,
                                                  input logic       psel,
                                                  input logic       ud0,
                                                  input logic       ud1);
      logic own;
      own = ch1 ? ud1 : ud0;
      if ((ch1 ? mfld[1] : mfld[0]) && own) begin
         ch_mode = psel ? cpw_pkg::CPW_UD_LOW : cpw_pkg::CPW_UD_HIGH;
      end else if (ch1 && psel && mfld == cpw_pkg::MF_UP && !ud0 && !ud1) begin
         ch_mode = cpw_pkg::CPW_DOUBLE;
      end else begin
         ch_mode = cpw_pkg::CPW_TOGGLE;
      end
   endfunction

   // reset released through two flops, asserted at once
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // apb phases; the slave answers in the first access cycle
   assign setup  = PSEL && !PENABLE;
   assign wr_en  = PSEL && PENABLE && PWRITE && pready_r;
   assign mapped = PADDR == cpw_pkg::ADDR_CTRL || PADDR == cpw_pkg::ADDR_CMP0 ||
                   PADDR == cpw_pkg::ADDR_CMP1 || PADDR == cpw_pkg::ADDR_STAT;

   // this pair's two bits of the shared mode field
   assign mf = ctrl_r.mode_field[2*PAIR_IDX +: 2];

   // per channel timer pick, transfer, effective compare and match
   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         tm[ch] = TIMERS[0];
         for (int t = 0; t < N_TMR; t++) begin
            if (ctrl_r.tsel[ch] == 2'(t)) begin
               tm[ch] = TIMERS[t];
            end
         end
         at_pk[ch] = tm[ch].count == tm[ch].peak;
         // peak transfer compares the freshly loaded value in the same step
         load[ch] = ctrl_r.buf_en[ch] && (tm[ch].stopped ||
                    (ctrl_r.peak_xfer[ch] ? at_pk[ch]
                                          : tm[ch].count == cpw_pkg::CMP_ZERO));
         eff[ch]  = load[ch] ? buf_r[ch] : cv_r[ch];
         hit[ch]  = ctrl_r.run[ch] && tm[ch].count == eff[ch];
      end
      mode[0] = ch_mode(1'b0, mf, ctrl_r.pair_sel, tm[0].updown, tm[1].updown);
      mode[1] = ch_mode(1'b1, mf, ctrl_r.pair_sel, tm[0].updown, tm[1].updown);
      for (int ch = 0; ch < 2; ch++) begin
         ud[ch]  = mode[ch] == cpw_pkg::CPW_UD_HIGH || mode[ch] == cpw_pkg::CPW_UD_LOW;
         act[ch] = mode[ch] != cpw_pkg::CPW_UD_LOW;
      end
   end

   // next output levels per mode
   always_comb begin
      rt_nxt = rt_r;
      for (int ch = 0; ch < 2; ch++) begin
         unique case (mode[ch])
            cpw_pkg::CPW_UD_HIGH, cpw_pkg::CPW_UD_LOW: begin
               if (ctrl_r.run[ch]) begin
                  if (eff[ch] == cpw_pkg::CMP_ZERO) begin
                     rt_nxt[ch] = act[ch];
                  end else if (eff[ch] == cpw_pkg::CMP_FULL) begin
                     rt_nxt[ch] = !act[ch];
                  end else if (hit[ch] && !at_pk[ch]) begin
                     // up drives active, down drives inactive
                     rt_nxt[ch] = tm[ch].down ? !act[ch] : act[ch];
                  end
               end
            end
            cpw_pkg::CPW_DOUBLE: begin
               // either compare flips output 1 once, even if both match
               if (hit[0] || hit[1]) begin
                  rt_nxt[ch] = !rt_r[ch];
               end
            end
            cpw_pkg::CPW_TOGGLE: begin
               // a value above peak simply never matches
               if (hit[ch]) begin
                  rt_nxt[ch] = !rt_r[ch];
               end
            end
         endcase
      end
   end

   // flags: hardware set wins over a software clear in the same cycle
   always_comb begin
      flag_nxt = flag_r;
      if (wr_en && PADDR == cpw_pkg::ADDR_STAT) begin
         flag_nxt = flag_r & ~PWDATA[cpw_pkg::S_FLAG +: 2];
      end
      for (int ch = 0; ch < 2; ch++) begin
         if (hit[ch] && !(ud[ch] && at_pk[ch])) begin
            flag_nxt[ch] = 1'b1;
         end
      end
   end

   // outputs and flags update at the edge that sees the match
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         rt_r   <= 2'h0;
         flag_r <= 2'h0;
      end else begin
         rt_r   <= rt_nxt;
         flag_r <= flag_nxt;
      end
   end

   // control word
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= cpw_pkg::CTRL_RST;
      end else if (wr_en && PADDR == cpw_pkg::ADDR_CTRL) begin
         ctrl_r.mode_field <= PWDATA[cpw_pkg::F_MODE +: 6];
         ctrl_r.pair_sel   <= PWDATA[cpw_pkg::F_PSEL];
         ctrl_r.run        <= PWDATA[cpw_pkg::F_RUN +: 2];
         ctrl_r.tsel       <= PWDATA[cpw_pkg::F_TSEL +: 4];
         ctrl_r.buf_en     <= PWDATA[cpw_pkg::F_BUFEN +: 2];
         ctrl_r.peak_xfer  <= PWDATA[cpw_pkg::F_PKX +: 2];
      end
   end

   // compare buffers and active values; buffer off writes straight through
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         buf_r <= '0;
         cv_r  <= '0;
      end else begin
         for (int ch = 0; ch < 2; ch++) begin
            if (wr_en && PADDR == (ch == 0 ? cpw_pkg::ADDR_CMP0 : cpw_pkg::ADDR_CMP1)) begin
               buf_r[ch] <= PWDATA[cpw_pkg::CW-1:0];
               if (!ctrl_r.buf_en[ch]) begin
                  cv_r[ch] <= PWDATA[cpw_pkg::CW-1:0];
               end else if (load[ch]) begin
                  cv_r[ch] <= buf_r[ch];
               end
            end else if (load[ch]) begin
               cv_r[ch] <= buf_r[ch];
            end
         end
      end
   end

   // apb answer captured in the setup cycle; reads show active compare values
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r  <= 32'h0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup && !mapped;
         if (setup && !PWRITE) begin
            prdata_r <= 32'h0;
            unique case (1'b1)
               PADDR == cpw_pkg::ADDR_CTRL: begin
                  prdata_r[cpw_pkg::F_MODE +: 6]  <= ctrl_r.mode_field;
                  prdata_r[cpw_pkg::F_PSEL]       <= ctrl_r.pair_sel;
                  prdata_r[cpw_pkg::F_RUN +: 2]   <= ctrl_r.run;
                  prdata_r[cpw_pkg::F_TSEL +: 4]  <= ctrl_r.tsel;
                  prdata_r[cpw_pkg::F_BUFEN +: 2] <= ctrl_r.buf_en;
                  prdata_r[cpw_pkg::F_PKX +: 2]   <= ctrl_r.peak_xfer;
               end
               PADDR == cpw_pkg::ADDR_CMP0: prdata_r[cpw_pkg::CW-1:0] <= cv_r[0];
               PADDR == cpw_pkg::ADDR_CMP1: prdata_r[cpw_pkg::CW-1:0] <= cv_r[1];
               PADDR == cpw_pkg::ADDR_STAT: begin
                  prdata_r[cpw_pkg::S_FLAG +: 2] <= flag_r;
                  prdata_r[cpw_pkg::S_RT +: 2]   <= rt_r;
               end
               default: prdata_r <= 32'h0; // unmapped reads zero
            endcase
         end
      end
   end

   assign PRDATA     = prdata_r;
   assign PREADY     = pready_r;
   assign PSLVERR    = pslverr_r;
   assign RT_OUT     = rt_r;
   assign MATCH_FLAG = flag_r;

   // single toggle inverts output 0 at a match
   property p_toggle0;
      @(posedge CLK_SYS) disable iff (!rst_n)
      mode[0] == cpw_pkg::CPW_TOGGLE && hit[0] |=> rt_r[0] != $past(rt_r[0]);
   endproperty
   a_toggle0: assert property (p_toggle0) else $error("ch0 did not toggle");

   // a stopped ch1 outside double toggle never moves its output
   property p_idle;
      @(posedge CLK_SYS) disable iff (!rst_n)
      !ctrl_r.run[1] && mode[1] != cpw_pkg::CPW_DOUBLE |=> $stable(rt_r[1]);
   endproperty
   a_idle: assert property (p_idle) else $error("disabled ch1 changed");

   // double toggle flips output 1 on either compare
   property p_double;
      @(posedge CLK_SYS) disable iff (!rst_n)
      mode[1] == cpw_pkg::CPW_DOUBLE && (hit[0] || hit[1]) |=> rt_r[1] != $past(rt_r[1]);
   endproperty
   a_double: assert property (p_double) else $error("double toggle missed");

   // up/down match counting up goes active
   property p_ud_up;
      @(posedge CLK_SYS) disable iff (!rst_n)
      ud[0] && hit[0] && !at_pk[0] && !tm[0].down && eff[0] != cpw_pkg::CMP_FULL
      |=> rt_r[0] == $past(act[0]);
   endproperty
   a_ud_up: assert property (p_ud_up) else $error("up match not active");

   // up/down match counting down goes inactive
   property p_ud_down;
      @(posedge CLK_SYS) disable iff (!rst_n)
      ud[1] && hit[1] && !at_pk[1] && tm[1].down && eff[1] != cpw_pkg::CMP_ZERO
      |=> rt_r[1] == !$past(act[1]);
   endproperty
   a_ud_down: assert property (p_ud_down) else $error("down match not inactive");

   // zero compare steady for two cycles leaves output active
   property p_all_act;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (ud[0] && ctrl_r.run[0] && eff[0] == cpw_pkg::CMP_ZERO)[*2] |-> rt_r[0] == act[0];
   endproperty
   a_all_act: assert property (p_all_act) else $error("zero compare not active");

   // full compare forces inactive
   property p_all_ina;
      @(posedge CLK_SYS) disable iff (!rst_n)
      ud[1] && ctrl_r.run[1] && eff[1] == cpw_pkg::CMP_FULL |=> rt_r[1] == !$past(act[1]);
   endproperty
   a_all_ina: assert property (p_all_ina) else $error("full compare not inactive");

   // peak match in up/down leaves output alone and sets no flag
   property p_peak;
      @(posedge CLK_SYS) disable iff (!rst_n)
      ud[0] && hit[0] && at_pk[0] && eff[0] != cpw_pkg::CMP_ZERO &&
      eff[0] != cpw_pkg::CMP_FULL && !flag_r[0] |=> $stable(rt_r[0]) && !flag_r[0];
   endproperty
   a_peak: assert property (p_peak) else $error("peak match acted");

   // a counted match raises the flag next edge
   property p_flag;
      @(posedge CLK_SYS) disable iff (!rst_n)
      hit[1] && !(ud[1] && at_pk[1]) |=> flag_r[1];
   endproperty
   a_flag: assert property (p_flag) else $error("match flag not set");

   // single toggle inverts output 1 at its own match
   property p_toggle1;
      @(posedge CLK_SYS) disable iff (!rst_n)
      mode[1] == cpw_pkg::CPW_TOGGLE && hit[1] |=> rt_r[1] != $past(rt_r[1]);
   endproperty
   a_toggle1: assert property (p_toggle1) else $error("ch1 did not toggle");

   // single toggle holds output 0 while the count misses
   property p_hold0;
      @(posedge CLK_SYS) disable iff (!rst_n)
      mode[0] == cpw_pkg::CPW_TOGGLE && !hit[0] |=> $stable(rt_r[0]);
   endproperty
   a_hold0: assert property (p_hold0) else $error("ch0 moved without a match");

   // under double toggle ch0 still flips on its own compare
   property p_dbl_ch0;
      @(posedge CLK_SYS) disable iff (!rst_n)
      mode[1] == cpw_pkg::CPW_DOUBLE && hit[0] |=> rt_r[0] != $past(rt_r[0]);
   endproperty
   a_dbl_ch0: assert property (p_dbl_ch0) else $error("ch0 idle in double mode");

   // a stopped ch0 never moves its output
   property p_idle0;
      @(posedge CLK_SYS) disable iff (!rst_n)
      !ctrl_r.run[0] |=> $stable(rt_r[0]);
   endproperty
   a_idle0: assert property (p_idle0) else $error("disabled ch0 changed");

   // a counted ch0 match raises its flag next edge
   property p_flag0;
      @(posedge CLK_SYS) disable iff (!rst_n)
      hit[0] && !(ud[0] && at_pk[0]) |=> flag_r[0];
   endproperty
   a_flag0: assert property (p_flag0) else $error("ch0 match flag not set");

endmodule
`default_nettype wire

// [rtl/cpw_pkg.sv]
`default_nettype none
package cpw_pkg;

   // compare and count width of the timers feeding the pair
   localparam int CW = 16;

   // compare values with a fixed meaning in the up/down modes
   localparam logic [CW-1:0] CMP_ZERO = 16'h0000;
   localparam logic [CW-1:0] CMP_FULL = 16'hffff;

   // apb byte addresses of the pair's registers
   localparam int             AW        = 8;
   localparam logic [AW-1:0]  ADDR_CTRL = 8'h00;
   localparam logic [AW-1:0]  ADDR_CMP0 = 8'h04;
   localparam logic [AW-1:0]  ADDR_CMP1 = 8'h08;
   localparam logic [AW-1:0]  ADDR_STAT = 8'h0c;

   // control word field positions
   localparam int F_MODE  = 0;   // pair mode field, 6 bits, two per pair
   localparam int F_PSEL  = 6;   // pair select bit
   localparam int F_RUN   = 8;   // run enables, ch0 then ch1
   localparam int F_TSEL  = 10;  // timer select, 2 bits per channel
   localparam int F_BUFEN = 16;  // buffer enables, ch0 then ch1
   localparam int F_PKX   = 18;  // peak-point transfer, ch0 then ch1

   // status word field positions
   localparam int S_FLAG = 0;    // match flags, write one to clear
   localparam int S_RT   = 4;    // real-time output levels

   // pair mode field codes
   localparam logic [1:0] MF_UP = 2'b00;

   // decoded channel modes, gray along toggle, double, up/down high, low
   typedef enum logic [1:0] {
      CPW_TOGGLE  = 2'b00,
      CPW_DOUBLE  = 2'b01,
      CPW_UD_HIGH = 2'b11,
      CPW_UD_LOW  = 2'b10
   } cpw_mode_t;

   // one free-running timer as seen by the compare pair
   typedef struct packed {
      logic [CW-1:0] count;
      logic [CW-1:0] peak;      // cycle setting value
      logic          updown;    // timer runs in up/down mode
      logic          down;      // timer is counting down
      logic          stopped;
   } cpw_tmr_t;

   // software control of the pair
   typedef struct packed {
      logic [5:0]      mode_field;
      logic            pair_sel;
      logic [1:0]      run;
      logic [1:0][1:0] tsel;
      logic [1:0]      buf_en;
      logic [1:0]      peak_xfer;
   } cpw_ctrl_t;

   localparam cpw_ctrl_t CTRL_RST = '0;

endpackage
`default_nettype wire

// [test/cpw_tmr_model.sv]
`timescale 1ns/100ps
`default_nettype none

// free-running timer seen by the pair: up-only wraps at peak,
// up/down turns round at peak and at zero
module cpw_tmr_model (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         run,
   input  wire logic         updown,
   input  wire logic [15:0]  peak,
   output var cpw_pkg::cpw_tmr_t tmr
);
   // count, direction and settings move together so the pair sees one state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr <= '0;
      end else begin
         tmr.peak    <= peak;
         tmr.updown  <= updown;
         tmr.stopped <= !run;
         if (run && !updown) begin
            tmr.count <= (tmr.count >= peak) ? 16'h0000 : tmr.count + 16'h0001;
            tmr.down  <= 1'b0;
         end else if (run && tmr.down) begin
            tmr.count <= tmr.count - 16'h0001;
            tmr.down  <= (tmr.count != 16'h0001); // clears down as the count reaches zero
         end else if (run) begin
            tmr.count <= tmr.count + 16'h0001;
            tmr.down  <= (tmr.count + 16'h0001 == peak);
         end
      end
   end
endmodule
`default_nettype wire

// [test/tb_compare_pair_output_waveform.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_compare_pair_output_waveform;
   logic CLK_SYS = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic PREADY, PSLVERR, tmr_run = 1'b0, dbl;
   logic [1:0] RT_OUT, MATCH_FLAG, ert, efl, m, s, ld;
   cpw_pkg::cpw_tmr_t [2:0] TIMERS;
   cpw_pkg::cpw_tmr_t tt [2];
   cpw_pkg::cpw_ctrl_t sc;
   logic [15:0] act [2], bfv [2];
   int n_fail = 0, num_checks = 0, cyc_cnt = 0, idx;

   // 40 MHz clock
   always #12.5 CLK_SYS = !CLK_SYS;

   cpw_compare_pair u_cpw_compare_pair (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMERS(TIMERS), .RT_OUT(RT_OUT),
      .MATCH_FLAG(MATCH_FLAG));

   // timer 0 up peak 9, timer 1 up/down peak 7, timer 2 up peak 12
   for (genvar i = 0; i < 3; i++) begin : g_tmr
      cpw_tmr_model u_cpw_tmr_model (.clk(CLK_SYS), .rst_n(RST_N), .run(tmr_run),
         .updown(i == 1), .peak(i == 0 ? 16'h0009 : (i == 1 ? 16'h0007 : 16'h000c)),
         .tmr(TIMERS[i]));
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; holds the request until pready is sampled high
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] ex, input logic ee);
      @(posedge CLK_SYS);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      // ends when pready is seen high, or at the bench's hang guard
      do begin
         @(posedge CLK_SYS);
      end while (PREADY !== 1'b1);
      if (!w) chk("read_data", ex, PRDATA);
      chk("slave_err", {31'h0, ee}, {31'h0, PSLVERR});
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask

   // reference of the pair, worked from pre-edge values at every edge
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         sc = '0;
         act = '{16'h0, 16'h0};
         bfv = '{16'h0, 16'h0};
         ert = 2'b00;
         efl = 2'b00;
      end else begin
         s = 2'b00;
         for (int c = 0; c < 2; c++) begin
            tt[c] = (sc.tsel[c] < 2'd3) ? TIMERS[sc.tsel[c]] : TIMERS[0];
            ld[c] = sc.buf_en[c] && (tt[c].stopped ||
                    tt[c].count == (sc.peak_xfer[c] ? tt[c].peak : 16'h0000));
            if (ld[c]) act[c] = bfv[c];
            m[c] = sc.run[c] && tt[c].count == act[c];
         end
         dbl = sc.mode_field[1:0] == 2'b00 && sc.pair_sel && !tt[0].updown && !tt[1].updown;
         for (int c = 0; c < 2; c++) begin
            if (sc.mode_field[c]) begin
               s[c] = m[c] && tt[c].count != tt[c].peak;
               if (sc.run[c] && act[c] == 16'h0000) ert[c] = !sc.pair_sel;
               else if (sc.run[c] && act[c] == 16'hffff) ert[c] = sc.pair_sel;
               else if (m[c] && tt[c].count != tt[c].peak) begin
                  ert[c] = tt[c].down ? sc.pair_sel : !sc.pair_sel;
               end
            end else begin
               s[c] = m[c];
               if (m[c] || (c == 1 && dbl && m[0])) ert[c] = !ert[c];
            end
         end
         if (PSEL && PENABLE && PREADY && PWRITE) begin
            case (PADDR)
               cpw_pkg::ADDR_CTRL: begin
                  sc.mode_field = PWDATA[5:0];
                  sc.pair_sel = PWDATA[6];
                  sc.run = PWDATA[9:8];
                  sc.tsel[0] = PWDATA[11:10];
                  sc.tsel[1] = PWDATA[13:12];
                  sc.buf_en = PWDATA[17:16];
                  sc.peak_xfer = PWDATA[19:18];
               end
               cpw_pkg::ADDR_CMP0, cpw_pkg::ADDR_CMP1: begin
                  idx = int'(PADDR[3]);
                  bfv[idx] = PWDATA[15:0];
                  if (!sc.buf_en[idx]) act[idx] = PWDATA[15:0];
               end
               cpw_pkg::ADDR_STAT: efl = efl & ~PWDATA[1:0];
               default: ;
            endcase
         end
         efl = efl | s; // a new match wins over a clear
      end
   end

   // outputs compared once settled, every cycle out of reset
   always @(negedge CLK_SYS) begin
      if (RST_N === 1'b1) begin
         chk("rt_out", {30'h0, ert}, {30'h0, RT_OUT});
         chk("match_flag", {30'h0, efl}, {30'h0, MATCH_FLAG});
      end
   end

   // hang guard
   always @(posedge CLK_SYS) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         n_fail++;
         give_verdict();
      end
   end

   initial begin
      repeat (10) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      cyc(3);
      for (int a = 0; a < 16; a += 4) acc(1'b0, 8'(a), 32'h0, 32'h0, 1'b0);
      tmr_run <= 1'b1;
      // both single-toggle, ch1 on timer 2; compares set only in listed modes
      wr(cpw_pkg::ADDR_CTRL, 32'h0000_2300);
      wr(cpw_pkg::ADDR_CMP0, 32'h0000_0003);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_000c);
      cyc(60);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_000d);
      wr(cpw_pkg::ADDR_CMP0, 32'h0000_0000);
      cyc(30);
      acc(1'b0, cpw_pkg::ADDR_CMP1, 32'h0, 32'h0000_000d, 1'b0);
      wr(cpw_pkg::ADDR_STAT, 32'h0000_0003);
      wr(cpw_pkg::ADDR_CTRL, 32'h0000_2200);
      cyc(30);
      acc(1'b0, cpw_pkg::ADDR_CTRL, 32'h0, 32'h0000_2200, 1'b0);
      wr(cpw_pkg::ADDR_CTRL, 32'h0000_233c);
      cyc(30);
      acc(1'b1, 8'h10, 32'hffff_ffff, 32'h0, 1'b1);
      acc(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
      // double toggle, both channels on timer 0 with the same settings
      wr(cpw_pkg::ADDR_CTRL, 32'h0000_0340);
      wr(cpw_pkg::ADDR_CMP0, 32'h0000_0002);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_0006);
      cyc(40);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_0002);
      cyc(30);
      wr(cpw_pkg::ADDR_CTRL, 32'h0003_0340);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_0009);
      cyc(40);
      wr(cpw_pkg::ADDR_CTRL, 32'h000f_0340);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_0004);
      cyc(20);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_0009);
      cyc(40);
      // up/down on timer 1
      wr(cpw_pkg::ADDR_CTRL, 32'h0000_2701);
      wr(cpw_pkg::ADDR_CMP0, 32'h0000_0003);
      cyc(40);
      wr(cpw_pkg::ADDR_CMP0, 32'h0000_0007);
      wr(cpw_pkg::ADDR_STAT, 32'h0000_0003);
      cyc(30);
      wr(cpw_pkg::ADDR_CMP0, 32'h0000_0000);
      cyc(20);
      wr(cpw_pkg::ADDR_CMP0, 32'h0000_ffff);
      cyc(20);
      wr(cpw_pkg::ADDR_CMP0, 32'h0000_0003);
      wr(cpw_pkg::ADDR_STAT, 32'h0000_0003);
      wr(cpw_pkg::ADDR_CTRL, 32'h0000_1342);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_0005);
      cyc(40);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_ffff);
      cyc(20);
      wr(cpw_pkg::ADDR_CMP1, 32'h0000_0005);
      wr(cpw_pkg::ADDR_CTRL, 32'h0000_1743);
      cyc(40);
      wr(cpw_pkg::ADDR_CTRL, 32'h0000_1703);
      cyc(40);
      wr(cpw_pkg::ADDR_CTRL, 32'h0003_1703);
      wr(cpw_pkg::ADDR_CMP0, 32'h0000_0002);
      cyc(40);
      give_verdict();
   end
endmodule
`default_nettype wire
